// [logic/brk_b_match.sv]
// channel b address and data match comparator with register port
//
// Behaviour
// - address mask bit 1 drops that address bit from the match, 0 compares.
// - xy enable 0: all 32 address mask bits act on logic address bus.
// - xy enable 1: upper half masks x address 15..1, lower half y.
// - xy enable 0: full 32-bit data value compared with logic data bus.
// - xy enable 1: data value 31..16 vs x data, 15..0 vs y data.
// - data mask bit 1 drops that data bit from the match, 0 compares.
// - data mask halves follow bus selection like the data value halves.
// - power-on reset clears address mask, data value, data mask to zero.
// - xy enable at bit 9, xy select at bit 8 of bus cycle register.
// - operand size 00 unchecked, 01 byte, 10 word, 11 longword.
//
// Added by the designer: the placing of the registers and the plain strobed port.
module brk_b_match
  import brk_b_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic [31:0] LOGIC_ADDRESS_BUS,
  input  wire logic [31:0] LOGIC_DATA_BUS,
  input  wire logic [15:0] X_MEMORY_ADDRESS_BUS,
  input  wire logic [15:0] X_MEMORY_DATA_BUS,
  input  wire logic [15:0] Y_MEMORY_ADDRESS_BUS,
  input  wire logic [15:0] Y_MEMORY_DATA_BUS,
  input  wire logic [1:0]  BUS_ACCESS_SIZE,
  output logic             ADDRESS_MATCH,
  output logic             DATA_MATCH,
  output logic             SIZE_MATCH
);

  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] addr_mask_reg, addr_mask_next;
  logic [31:0] data_value_reg, data_value_next;
  logic [31:0] data_mask_reg, data_mask_next;
  logic [31:0] addr_value_reg, addr_value_next;
  logic [15:0] bus_cycle_reg, bus_cycle_next;
  logic [31:0] rdata_reg, rdata_next;

  logic             xy_bus_enable;
  logic             xy_bus_select;
  operand_size_type size_sel;

  assign xy_bus_enable = bus_cycle_reg[XY_ENABLE_BIT];
  assign xy_bus_select = bus_cycle_reg[XY_SELECT_BIT];
  assign size_sel = operand_size_type'(bus_cycle_reg[SIZE_LSB +: 2]);

  always_comb begin
    addr_mask_next  = addr_mask_reg;
    data_value_next = data_value_reg;
    data_mask_next  = data_mask_reg;
    addr_value_next = addr_value_reg;
    bus_cycle_next  = bus_cycle_reg;
    rdata_next      = 32'h00000000;
    if (REG_WR) begin
      case (REG_ADDR)
        ADDR_MASK_OFS:  addr_mask_next  = REG_WDATA;
        DATA_VALUE_OFS: data_value_next = REG_WDATA;
        DATA_MASK_OFS:  data_mask_next  = REG_WDATA;
        ADDR_VALUE_OFS: addr_value_next = REG_WDATA;
        BUS_CYCLE_OFS:  bus_cycle_next  = REG_WDATA[15:0] & BUS_CYCLE_WMASK;
        default: ;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        ADDR_MASK_OFS:  rdata_next = addr_mask_reg;
        DATA_VALUE_OFS: rdata_next = data_value_reg;
        DATA_MASK_OFS:  rdata_next = data_mask_reg;
        ADDR_VALUE_OFS: rdata_next = addr_value_reg;
        BUS_CYCLE_OFS:  rdata_next = {16'h0000, bus_cycle_reg};
        STATUS_OFS:     rdata_next = {29'h00000000, SIZE_MATCH,
                                      DATA_MATCH, ADDRESS_MATCH};
        default:        rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_mask_reg  <= ADDR_MASK_RST;
      data_value_reg <= DATA_VALUE_RST;
      data_mask_reg  <= DATA_MASK_RST;
      addr_value_reg <= ADDR_VALUE_RST;
      bus_cycle_reg  <= BUS_CYCLE_RST;
      rdata_reg      <= 32'h00000000;
    end else begin
      addr_mask_reg  <= addr_mask_next;
      data_value_reg <= data_value_next;
      data_mask_reg  <= data_mask_next;
      addr_value_reg <= addr_value_next;
      bus_cycle_reg  <= bus_cycle_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

  // ************************************************************
  // comparators
  // ************************************************************
  logic [31:0] addr_bus, addr_val, addr_msk;
  logic [31:0] data_bus, data_val, data_msk;
  logic        addr_hit, data_hit, size_hit;
  logic        addr_match_reg, data_match_reg, size_match_reg;

  // steer bus, value and mask halves by the bus selection
  always_comb begin
    if (!xy_bus_enable) begin
      addr_bus = LOGIC_ADDRESS_BUS;
      addr_val = addr_value_reg;
      addr_msk = addr_mask_reg;
      data_bus = LOGIC_DATA_BUS;
      data_val = data_value_reg;
      data_msk = data_mask_reg;
    end else if (!xy_bus_select) begin
      // bit 0 of the xy address is not compared
      addr_bus = {16'h0000, X_MEMORY_ADDRESS_BUS[15:1], 1'b0};
      addr_val = {16'h0000, addr_value_reg[31:17], 1'b0};
      addr_msk = {16'hFFFF, addr_mask_reg[31:17], 1'b1};
      data_bus = {16'h0000, X_MEMORY_DATA_BUS};
      data_val = {16'h0000, data_value_reg[31:16]};
      data_msk = {16'hFFFF, data_mask_reg[31:16]};
    end else begin
      addr_bus = {16'h0000, Y_MEMORY_ADDRESS_BUS[15:1], 1'b0};
      addr_val = {16'h0000, addr_value_reg[15:1], 1'b0};
      addr_msk = {16'hFFFF, addr_mask_reg[15:1], 1'b1};
      data_bus = {16'h0000, Y_MEMORY_DATA_BUS};
      data_val = {16'h0000, data_value_reg[15:0]};
      data_msk = {16'hFFFF, data_mask_reg[15:0]};
    end
    addr_hit = ~|((addr_bus ^ addr_val) & ~addr_msk);
    data_hit = ~|((data_bus ^ data_val) & ~data_msk);
    // unchecked size always matches
    size_hit = (size_sel == SIZE_NONE) ||
               (BUS_ACCESS_SIZE == size_sel);
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_match_reg <= 1'b0;
      data_match_reg <= 1'b0;
      size_match_reg <= 1'b0;
    end else begin
      addr_match_reg <= addr_hit;
      data_match_reg <= data_hit;
      size_match_reg <= size_hit;
    end
  end

  assign ADDRESS_MATCH = addr_match_reg;
  assign DATA_MATCH    = data_match_reg;
  assign SIZE_MATCH    = size_match_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence full_bus_s;
    !xy_bus_enable;
  endsequence

  sequence x_bus_s;
    xy_bus_enable && !xy_bus_select;
  endsequence

  sequence y_bus_s;
    xy_bus_enable && xy_bus_select;
  endsequence

  sequence write_mask_s;
    REG_WR && REG_ADDR == ADDR_MASK_OFS;
  endsequence

  sequence read_mask_s;
    REG_RD && !REG_WR && REG_ADDR == ADDR_MASK_OFS;
  endsequence

  sequence write_value_s;
    REG_WR && REG_ADDR == DATA_VALUE_OFS;
  endsequence

  sequence read_value_s;
    REG_RD && !REG_WR && REG_ADDR == DATA_VALUE_OFS;
  endsequence

  sequence write_dmask_s;
    REG_WR && REG_ADDR == DATA_MASK_OFS;
  endsequence

  sequence read_dmask_s;
    REG_RD && !REG_WR && REG_ADDR == DATA_MASK_OFS;
  endsequence

  sequence write_cycle_s;
    REG_WR && REG_ADDR == BUS_CYCLE_OFS;
  endsequence

  addr_compare_a: assert property (
    full_bus_s |=> ADDRESS_MATCH == ~|(($past(LOGIC_ADDRESS_BUS) ^
      $past(addr_value_reg)) & ~$past(addr_mask_reg)))
    else $error("address match wrong on logic bus");

  data_compare_a: assert property (
    full_bus_s |=> DATA_MATCH == ~|(($past(LOGIC_DATA_BUS) ^
      $past(data_value_reg)) & ~$past(data_mask_reg)))
    else $error("data match wrong on logic bus");

  addr_masked_a: assert property (
    full_bus_s ##0 (&addr_mask_reg) |=> ADDRESS_MATCH)
    else $error("full address mask did not force match");

  data_masked_a: assert property (
    full_bus_s ##0 (&data_mask_reg) |=> DATA_MATCH)
    else $error("full data mask did not force match");

  mask_all_a: assert property (
    (&addr_mask_reg && &data_mask_reg) |=> ADDRESS_MATCH && DATA_MATCH)
    else $error("full mask did not force match");

  x_addr_a: assert property (
    x_bus_s ##0 (addr_mask_reg[31:17] == 15'h0000)
    |=> ADDRESS_MATCH == ($past(X_MEMORY_ADDRESS_BUS[15:1]) ==
                          $past(addr_value_reg[31:17])))
    else $error("x address compare wrong");

  x_data_a: assert property (
    x_bus_s ##0 (data_mask_reg[31:16] == 16'h0000)
    |=> DATA_MATCH == ($past(X_MEMORY_DATA_BUS) ==
                       $past(data_value_reg[31:16])))
    else $error("x data compare wrong");

  y_addr_a: assert property (
    y_bus_s ##0 (addr_mask_reg[15:1] == 15'h0000)
    |=> ADDRESS_MATCH == ($past(Y_MEMORY_ADDRESS_BUS[15:1]) ==
                          $past(addr_value_reg[15:1])))
    else $error("y address compare wrong");

  y_amask_a: assert property (
    y_bus_s ##0 (&addr_mask_reg[15:1]) |=> ADDRESS_MATCH)
    else $error("y address mask did not force match");

  y_data_a: assert property (
    y_bus_s ##0 (data_mask_reg[15:0] == 16'h0000)
    |=> DATA_MATCH == ($past(Y_MEMORY_DATA_BUS) ==
                       $past(data_value_reg[15:0])))
    else $error("y data compare wrong");

  y_dmask_a: assert property (
    y_bus_s ##0 (&data_mask_reg[15:0]) |=> DATA_MATCH)
    else $error("y data mask did not force match");

  mask_write_a: assert property (
    write_mask_s ##1 read_mask_s |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("address mask readback differs from write");

  value_write_a: assert property (
    write_value_s ##1 read_value_s |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("data value readback differs from write");

  dmask_write_a: assert property (
    write_dmask_s ##1 read_dmask_s |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("data mask readback differs from write");

  status_read_a: assert property (
    (REG_RD && REG_ADDR == STATUS_OFS) |=> REG_RDATA ==
      {29'h00000000, $past(SIZE_MATCH), $past(DATA_MATCH),
       $past(ADDRESS_MATCH)})
    else $error("status readback differs from match outputs");

  size_check_a: assert property (
    (size_sel != SIZE_NONE && BUS_ACCESS_SIZE != size_sel) |=> !SIZE_MATCH)
    else $error("size mismatch not seen");

  size_none_a: assert property (
    size_sel == SIZE_NONE |=> SIZE_MATCH)
    else $error("unchecked size did not match");

  size_equal_a: assert property (
    BUS_ACCESS_SIZE == size_sel |=> SIZE_MATCH)
    else $error("equal size did not match");

  enable_bit_a: assert property (
    write_cycle_s |=> xy_bus_enable == $past(REG_WDATA[XY_ENABLE_BIT]))
    else $error("xy enable not at its bit");

  select_bit_a: assert property (
    write_cycle_s |=> xy_bus_select == $past(REG_WDATA[XY_SELECT_BIT]))
    else $error("xy select not at its bit");

endmodule

// [shared/brk_b_pkg.sv]
// constants for the channel b address and data match block
package brk_b_pkg;
  localparam logic [3:0]  ADDR_MASK_OFS   = 4'h0;
  localparam logic [3:0]  DATA_VALUE_OFS  = 4'h4;
  localparam logic [3:0]  DATA_MASK_OFS   = 4'h8;
  localparam logic [3:0]  ADDR_VALUE_OFS  = 4'hC;
  localparam logic [3:0]  BUS_CYCLE_OFS   = 4'h1;
  localparam logic [3:0]  STATUS_OFS      = 4'h2;
  localparam logic [31:0] ADDR_MASK_RST   = 32'h00000000;
  localparam logic [31:0] DATA_VALUE_RST  = 32'h00000000;
  localparam logic [31:0] DATA_MASK_RST   = 32'h00000000;
  localparam logic [31:0] ADDR_VALUE_RST  = 32'h00000000;
  localparam logic [15:0] BUS_CYCLE_RST   = 16'h0000;
  localparam int          XY_ENABLE_BIT   = 9;
  localparam int          XY_SELECT_BIT   = 8;
  localparam int          SIZE_LSB        = 0;
  localparam logic [15:0] BUS_CYCLE_WMASK = 16'h03FF;
  typedef enum logic [1:0] {
    SIZE_NONE = 2'b00,
    SIZE_BYTE = 2'b01,
    SIZE_WORD = 2'b10,
    SIZE_LONG = 2'b11
  } operand_size_type;
endpackage

// [verif/bus_model.sv]
// processor bus model driving the logic, x and y buses
module bus_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  sel,
  input  wire logic [31:0] adr,
  input  wire logic [31:0] dat,
  output logic      [31:0] la,
  output logic      [31:0] ld,
  output logic      [15:0] xa,
  output logic      [15:0] xd,
  output logic      [15:0] ya,
  output logic      [15:0] yd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] junk_reg;
  logic [15:0] junk_next;
  // idle buses wander so stale values never line up
  always_comb begin
    junk_next = junk_reg * 16'h0005 + 16'h3C3B;
    la = {junk_reg, ~junk_reg};
    ld = {~junk_reg, junk_reg};
    {xa, xd, ya, yd} = {junk_reg, ~junk_reg, ~junk_reg, junk_reg};
    if (sel == 2'h0) begin
      {la, ld} = {adr, dat};
    end else if (sel == 2'h1) begin
      {xa, xd} = {adr[15:0], dat[15:0]};
    end else begin
      {ya, yd} = {adr[15:0], dat[15:0]};
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) junk_reg <= 16'h1234;
    else junk_reg <= junk_next;
  end
endmodule

// [verif/tb_brk_b_match.sv]
// self-checking bench for the channel b match block
module tb_brk_b_match;
  import brk_b_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("Error %0t got %h exp %h", $time, a, e); end end
  logic        core_clk, reset_n, wr, rd, am, dm, sm;
  logic [3:0]  addr;
  logic [1:0]  sel, asize;
  logic [31:0] wdata, rdata, adr, dat, la, ld;
  logic [15:0] xa, xd, ya, yd;
  int          num_errors, num_checks;
  brk_b_match brk_b_match_i (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .LOGIC_ADDRESS_BUS(la), .LOGIC_DATA_BUS(ld),
    .X_MEMORY_ADDRESS_BUS(xa), .X_MEMORY_DATA_BUS(xd),
    .Y_MEMORY_ADDRESS_BUS(ya), .Y_MEMORY_DATA_BUS(yd),
    .BUS_ACCESS_SIZE(asize), .ADDRESS_MATCH(am), .DATA_MATCH(dm),
    .SIZE_MATCH(sm));
  bus_model bus_model_i (.core_clk(core_clk), .reset_n(reset_n),
    .sel(sel), .adr(adr), .dat(dat), .la(la), .ld(ld), .xa(xa),
    .xd(xd), .ya(ya), .yd(yd));
  // ****************************************
  // bus tasks
  // ****************************************
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    {rd, addr} <= {1'b1, a};
    @(posedge core_clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task wr_rd_chk(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    {wr, rd} <= 2'b01;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 `CHK(rdata, d)
    @(posedge core_clk);
    #1 `CHK(rdata, 32'h00000000)
  endtask
  task bus_chk(input logic [1:0] s, input logic [31:0] a, d,
               input logic [1:0] e);
    @(posedge core_clk);
    {sel, adr, dat} <= {s, a, d};
    @(posedge core_clk);
    #1 `CHK({am, dm}, e)
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    logic [3:0] ofs [3];
    ofs = '{ADDR_MASK_OFS, DATA_VALUE_OFS, DATA_MASK_OFS};
    for (int i = 0; i < 3; i++) begin
      rd_chk(ofs[i], 32'h00000000);
      wr_rd_chk(ofs[i], 32'hA5C30F1E ^ 32'(i));
      wr_reg(ofs[i], 32'h00000000);
    end
    wr_reg(4'hF, 32'hFFFFFFFF);
    rd_chk(4'hF, 32'h00000000);
    $display("t_regs done");
  endtask
  task t_logic;
    int bits [4];
    logic [31:0] b;
    bits = '{0, 15, 16, 31};
    wr_reg(ADDR_VALUE_OFS, 32'h89AB4567);
    wr_reg(DATA_VALUE_OFS, 32'h0F1E2D3C);
    bus_chk(2'h0, 32'h89AB4567, 32'h0F1E2D3C, 2'b11);
    for (int k = 0; k < 4; k++) begin
      b = 32'h00000001 << bits[k];
      bus_chk(2'h0, 32'h89AB4567 ^ b, 32'h0F1E2D3C ^ b, 2'b00);
      wr_reg(ADDR_MASK_OFS, b);
      wr_reg(DATA_MASK_OFS, b);
      bus_chk(2'h0, 32'h89AB4567 ^ b, 32'h0F1E2D3C ^ b, 2'b11);
    end
    wr_reg(ADDR_MASK_OFS, 32'hFFFFFFFF);
    wr_reg(DATA_MASK_OFS, 32'hFFFFFFFF);
    bus_chk(2'h0, 32'h76543210, 32'hFEDCBA98, 2'b11);
    $display("t_logic done");
  endtask
  task t_xy;
    wr_reg(ADDR_MASK_OFS, 32'h00000000);
    wr_reg(DATA_MASK_OFS, 32'h00000000);
    wr_reg(ADDR_VALUE_OFS, 32'h5A5A1357);
    wr_reg(DATA_VALUE_OFS, 32'hC0DE2424);
    wr_reg(BUS_CYCLE_OFS, 32'h00000202);
    bus_chk(2'h1, 32'h5A5A, 32'hC0DE, 2'b11);
    bus_chk(2'h1, 32'h5A5B, 32'hC0DF, 2'b10);
    bus_chk(2'h1, 32'h5A58, 32'h40DE, 2'b00);
    wr_reg(ADDR_MASK_OFS, 32'h00020000);
    wr_reg(DATA_MASK_OFS, 32'h80010000);
    bus_chk(2'h1, 32'h5A58, 32'h40DF, 2'b11);
    wr_reg(BUS_CYCLE_OFS, 32'h00000301);
    bus_chk(2'h2, 32'h1357, 32'h2424, 2'b11);
    bus_chk(2'h2, 32'h1356, 32'h2425, 2'b10);
    bus_chk(2'h2, 32'h1355, 32'h2424, 2'b01);
    wr_reg(ADDR_MASK_OFS, 32'h00000002);
    wr_reg(DATA_MASK_OFS, 32'h00000001);
    bus_chk(2'h2, 32'h1355, 32'h2425, 2'b11);
    wr_reg(ADDR_MASK_OFS, 32'hFFFFFFFF);
    wr_reg(DATA_MASK_OFS, 32'hFFFFFFFF);
    bus_chk(2'h2, 32'h0000, 32'hFFFF, 2'b11);
    rd_chk(STATUS_OFS, 32'h00000003);
    $display("t_xy done");
  endtask
  task t_size;
    wr_reg(BUS_CYCLE_OFS, 32'hFFFFFFFF);
    rd_chk(BUS_CYCLE_OFS, 32'h000003FF);
    for (int s = 0; s < 4; s++) begin
      wr_reg(BUS_CYCLE_OFS, 32'(s));
      for (int b = 1; b < 4; b++) begin
        @(posedge core_clk);
        asize <= 2'(b);
        @(posedge core_clk);
        #1 `CHK(sm, (s == 0 || s == b))
      end
    end
    $display("t_size done");
  endtask
  task t_reset;
    wr_reg(ADDR_MASK_OFS, 32'h13579BDF);
    wr_reg(DATA_VALUE_OFS, 32'h2468ACE0);
    wr_reg(DATA_MASK_OFS, 32'hFEDCBA98);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd_chk(ADDR_MASK_OFS, ADDR_MASK_RST);
    rd_chk(DATA_VALUE_OFS, DATA_VALUE_RST);
    rd_chk(DATA_MASK_OFS, DATA_MASK_RST);
    $display("t_reset done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, wr, rd, addr, wdata, sel, adr, dat, asize} = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs;
    t_logic;
    t_xy;
    t_size;
    t_reset;
    end_sim;
  end
  initial begin
    #2000000;
    num_errors++;
    end_sim;
  end
endmodule
